/* File: rtl/ebc_pkg.sv */
`default_nettype none
package ebc_pkg;
  // Register offsets: word addresses, so all five fit the 4-bit port
  localparam logic [3:0] ADDR_TIMING = 4'h0;
  localparam logic [3:0] ADDR_CTRL = 4'h1;
  localparam logic [3:0] ADDR_ADDR = 4'h2;
  localparam logic [3:0] ADDR_DATA = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  // Timing register fields
  localparam int TF_AB = 0;
  localparam int TF_AB_EXT = 1;
  localparam int TF_C = 3;
  localparam int TF_D = 5;
  localparam int TF_E = 6;
  localparam int TF_F = 11;
  localparam logic [12:0] TIMING_RST = 13'h0000;
  // Control register fields
  localparam int CF_RDY_EN = 0;
  localparam int CF_RDY_POL = 1;
  localparam int CF_RDY_ASYNC = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  // Command register: bit0 start, bit1 write, bits 31:16 address, window id from bits 31:28
  localparam int CMD_START = 0;
  localparam int CMD_WRITE = 1;

  typedef struct packed {
    logic [1:0] f;
    logic [4:0] e;
    logic d;
    logic [1:0] c;
    logic [1:0] ab_ext;
    logic ab;
  } ebc_timing_t;

  typedef struct packed {
    logic rd_n;
    logic wr_n;
    logic ale;
  } ebc_strobe_t;

  typedef enum logic [3:0] {
    S_IDLE, S_AB, S_C, S_D, S_E, S_RDY, S_F,
    S_REL, S_HELD, S_REGAIN
  } ebc_state_t;
endpackage
`default_nettype wire

/* File: rtl/ebc_ctrl.sv */
// Summary of operation
// - Each bus cycle runs five phases with programmed durations.
// - Address setup one or two periods, plus zero to three on window change.
// - Command delay one to four periods; write-data setup one or two periods.
// - Access one to thirty-two periods; hold one to four periods.
// - With ready enabled the external module ends the access phase.
// - Ready polarity is selectable and applied to the sampled level.
// - Asynchronous ready passes an extra stage, adding at least one wait.
// - Ready inactive adds one wait; active ends the cycle.
// - Read data latched on the edge that raises the read strobe.
// - Running cycle finishes before the bus is granted.
// - Strobes driven inactive before floating, and again before reuse.
// - Regain starts only when the hold input hold_n_in goes high, so hold_req drops.
// - Master may drop hold anytime; device then reclaims normally.
//
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`default_nettype none
module ebc_ctrl (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic bus_reference_clock_out,
  output logic [15:0] addr_out,
  output logic [15:0] data_out,
  output logic data_oe,
  input wire logic [15:0] data_in,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic ale_out,
  output logic ctrl_oe,
  input wire logic ready_in,
  input wire logic hold_n_in,
  output logic hold_grant_out,
  output logic bus_reclaim_request
);
  ebc_pkg::ebc_timing_t chip_select_timing_config;
  logic [2:0] ctrl;
  logic [15:0] addr_reg;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [15:0] window;
  logic [15:0] last_window;
  logic pend;
  logic pend_write;
  logic done_flag;
  ebc_pkg::ebc_state_t state;
  logic [4:0] cnt;
  logic [1:0] rdy_sync;
  logic rdy_async;
  logic [1:0] hold_sync;
  logic rdy_active;
  logic rdy_raw;

  // Reference clock: CPU clock divided by two, one bus period per phase unit
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      bus_reference_clock_out <= 1'b0;
    else
      bus_reference_clock_out <= ~bus_reference_clock_out;
  end
  wire logic tick = bus_reference_clock_out;

  // Input synchronisers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdy_sync <= 2'h0;
      hold_sync <= 2'h3;
    end
    else
    begin
      rdy_sync <= {rdy_sync[0], ready_in};
      hold_sync <= {hold_sync[0], hold_n_in};
    end
  end

  // Extra stage for asynchronous ready costs one more bus period
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdy_async <= 1'b0;
    else if (tick)
      rdy_async <= rdy_sync[1];
  end

  always_comb
  begin
    rdy_raw = ctrl[ebc_pkg::CF_RDY_ASYNC] ? rdy_async : rdy_sync[1];
    rdy_active = rdy_raw ^ ~ctrl[ebc_pkg::CF_RDY_POL];
  end

  wire logic hold_req = ~hold_sync[1];
  wire logic bus_cycle = (state != ebc_pkg::S_IDLE)
    && (state != ebc_pkg::S_REL) && (state != ebc_pkg::S_HELD)
    && (state != ebc_pkg::S_REGAIN);

  // Avalon slave: one wait cycle, then answer
  logic acc_d;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      acc_d <= 1'b0;
    else
      acc_d <= (avs_read | avs_write) & ~acc_d;
  end
  assign avs_waitrequest = (avs_read | avs_write) & ~acc_d;
  wire logic wr_take = avs_write & acc_d;
  wire logic start_req = wr_take && avs_address == ebc_pkg::ADDR_ADDR
    && avs_writedata[ebc_pkg::CMD_START] && !pend;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chip_select_timing_config <= ebc_pkg::TIMING_RST;
      ctrl <= ebc_pkg::CTRL_RST;
      wdata <= 16'h0000;
    end
    else if (wr_take)
    begin
      if (avs_address == ebc_pkg::ADDR_TIMING)
        chip_select_timing_config <= avs_writedata[12:0];
      if (avs_address == ebc_pkg::ADDR_CTRL)
        ctrl <= avs_writedata[2:0];
      if (avs_address == ebc_pkg::ADDR_DATA)
        wdata <= avs_writedata[15:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend <= 1'b0;
      pend_write <= 1'b0;
      addr_reg <= 16'h0000;
      window <= 16'h0000;
    end
    else if (start_req)
    begin
      pend <= 1'b1;
      pend_write <= avs_writedata[ebc_pkg::CMD_WRITE];
      addr_reg <= avs_writedata[31:16];
      window <= {12'h000, avs_writedata[31:28]};
    end
    else if (state == ebc_pkg::S_F && tick && cnt == 5'h00)
      pend <= 1'b0;
  end

  always_comb
  begin
    avs_readdata = 32'h00000000;
    case (avs_address)
      ebc_pkg::ADDR_TIMING:
        avs_readdata = {19'h00000, chip_select_timing_config};
      ebc_pkg::ADDR_CTRL:
        avs_readdata = {29'h00000000, ctrl};
      ebc_pkg::ADDR_ADDR:
        avs_readdata = {addr_reg, 16'h0000};
      ebc_pkg::ADDR_DATA:
        avs_readdata = {16'h0000, rdata};
      ebc_pkg::ADDR_STATUS:
        avs_readdata = {27'h0000000, done_flag, hold_grant_out,
          bus_reclaim_request, pend, bus_cycle};
      default:
        avs_readdata = 32'h00000000;
    endcase
  end

  // Phase sequencer; all phase counts step on reference clock periods
  wire ebc_pkg::ebc_timing_t t = chip_select_timing_config;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ebc_pkg::S_IDLE;
      cnt <= 5'h00;
      last_window <= 16'h0000;
    end
    else if (tick)
    begin
      case (state)
        ebc_pkg::S_IDLE:
          if (hold_req)
            state <= ebc_pkg::S_REL;
          else if (pend)
          begin
            state <= ebc_pkg::S_AB;
            if (window != last_window)
              cnt <= 5'(t.ab) + 5'(t.ab_ext);
            else
              cnt <= 5'(t.ab);
            last_window <= window;
          end
        ebc_pkg::S_AB:
          if (cnt != 5'h00)
            cnt <= cnt - 5'h01;
          else
          begin
            state <= ebc_pkg::S_C;
            cnt <= 5'(t.c);
          end
        ebc_pkg::S_C:
          if (cnt != 5'h00)
            cnt <= cnt - 5'h01;
          else
          begin
            state <= ebc_pkg::S_D;
            cnt <= 5'(t.d);
          end
        ebc_pkg::S_D:
          if (cnt != 5'h00)
            cnt <= cnt - 5'h01;
          else
          begin
            state <= ebc_pkg::S_E;
            cnt <= t.e;
          end
        ebc_pkg::S_E:
          if (cnt != 5'h00)
            cnt <= cnt - 5'h01;
          else if (ctrl[ebc_pkg::CF_RDY_EN] && !rdy_active)
            state <= ebc_pkg::S_RDY;
          else
          begin
            state <= ebc_pkg::S_F;
            cnt <= 5'(t.f);
          end
        ebc_pkg::S_RDY:
          if (rdy_active)
          begin
            state <= ebc_pkg::S_F;
            cnt <= 5'(t.f);
          end
        ebc_pkg::S_F:
          if (cnt != 5'h00)
            cnt <= cnt - 5'h01;
          else
            state <= ebc_pkg::S_IDLE;
        ebc_pkg::S_REL:
          state <= ebc_pkg::S_HELD;
        ebc_pkg::S_HELD:
          if (!hold_req)
            state <= ebc_pkg::S_REGAIN;
        ebc_pkg::S_REGAIN:
          state <= ebc_pkg::S_IDLE;
        default:
          state <= ebc_pkg::S_IDLE;
      endcase
    end
  end

  // Read data captured on the edge that raises the read strobe
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 16'h0000;
    else if (!rd_n_out && state != ebc_pkg::S_E && state != ebc_pkg::S_RDY)
      rdata <= data_in;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      done_flag <= 1'b0;
    else if (start_req)
      done_flag <= 1'b0;
    else if (tick && state == ebc_pkg::S_F && cnt == 5'h00)
      done_flag <= 1'b1;
  end

  // Pin outputs
  ebc_pkg::ebc_strobe_t next_strobe;
  always_comb
  begin
    next_strobe = '{rd_n: 1'b1, wr_n: 1'b1, ale: 1'b0};
    if (state == ebc_pkg::S_AB)
      next_strobe.ale = 1'b1;
    if (state == ebc_pkg::S_E || state == ebc_pkg::S_RDY)
    begin
      next_strobe.rd_n = pend_write;
      next_strobe.wr_n = ~pend_write;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_n_out <= 1'b1;
      wr_n_out <= 1'b1;
      ale_out <= 1'b0;
      ctrl_oe <= 1'b1;
      addr_out <= 16'h0000;
      data_out <= 16'h0000;
      data_oe <= 1'b0;
    end
    else
    begin
      rd_n_out <= next_strobe.rd_n;
      wr_n_out <= next_strobe.wr_n;
      ale_out <= next_strobe.ale;
      // Strobes stay driven inactive in the release and regain states
      ctrl_oe <= state != ebc_pkg::S_HELD;
      addr_out <= addr_reg;
      data_out <= wdata;
      data_oe <= pend_write && (state == ebc_pkg::S_D
        || state == ebc_pkg::S_E || state == ebc_pkg::S_RDY
        || state == ebc_pkg::S_F);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold_grant_out <= 1'b0;
      bus_reclaim_request <= 1'b0;
    end
    else
    begin
      hold_grant_out <= state == ebc_pkg::S_HELD && hold_req;
      bus_reclaim_request <= state == ebc_pkg::S_HELD && pend;
    end
  end
endmodule
`default_nettype wire

/* File: dv/ebc_chk.sv */
`default_nettype none
module ebc_chk (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic rd_n_out,
  input wire logic wr_n_out,
  input wire logic ale_out,
  input wire logic ctrl_oe,
  input wire logic data_oe,
  input wire logic hold_n_in,
  input wire logic hold_grant_out,
  input wire logic bus_reclaim_request
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  sequence s_idle_drive;
    rd_n_out && wr_n_out && !ale_out && ctrl_oe;
  endsequence
  a_avs_one_wait: assert property (
    $rose(avs_read | avs_write) |-> s_one_wait) else $error("late answer");
  a_strobe_excl: assert property (
    rd_n_out | wr_n_out) else $error("both strobes low");
  a_read_no_drive: assert property (
    !rd_n_out |-> !data_oe) else $error("data driven in read");
  a_grant_float: assert property (
    hold_grant_out |-> !ctrl_oe) else $error("driven while granted");
  a_float_after_idle: assert property (
    $fell(ctrl_oe) |-> $past(rd_n_out & wr_n_out & !ale_out))
    else $error("floated without idle drive");
  a_regain_idle: assert property (
    $rose(ctrl_oe) |-> s_idle_drive) else $error("regain not idle");
  a_grant_after_hold: assert property (
    $rose(hold_grant_out) |-> !$past(hold_n_in, 3) && $past(rd_n_out & wr_n_out))
    else $error("grant without hold");
  a_hold_keeps_grant: assert property (
    !hold_n_in [*4] |-> !$fell(hold_grant_out)) else $error("early regain");
  a_reclaim_held: assert property (
    $rose(bus_reclaim_request) |-> hold_grant_out) else $error("bad reclaim");
  a_regain_drive: assert property (
    $fell(hold_grant_out) |-> ##[1:2] $rose(ctrl_oe))
    else $error("regain not driven");
endmodule
`default_nettype wire

/* File: dv/ebc_mem.sv */
`default_nettype none
module ebc_mem (
  input wire logic ref_clk,
  input wire logic clk_out,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [3:0] dly,
  input wire logic pol,
  output logic ready,
  output logic [15:0] rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [16];
  logic clk_q = 0;
  logic rdy = 0;
  logic [3:0] cnt = 4'h0;
  initial rdata = 16'h5a5a;
  assign ready = !(rdy ^ pol);
  always @(posedge ref_clk)
  begin
    clk_q <= clk_out;
    // Ready drops with the command, well before the next sample point
    if (rd_n & wr_n)
    begin
      cnt <= 4'h0;
      rdy <= 1'b0;
    end
    // Held until the command ends, so longer than one bus period
    else if (clk_out & !clk_q)
    begin
      if (cnt >= dly)
        rdy <= 1'b1;
      else
        cnt <= cnt + 4'h1;
    end
    if (!wr_n)
      mem[addr[3:0]] <= wdata;
    // Released read data toggles so a late capture cannot match
    rdata <= !rd_n ? mem[addr[3:0]] : ~rdata;
  end
endmodule
`default_nettype wire

/* File: dv/ebc_ctrl_tb.sv */
`default_nettype none
module ebc_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0;
  logic hold_n_in = 1, pol = 1;
  logic [3:0] avs_address = 4'h0, dly = 4'h3;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic avs_waitrequest, bus_reference_clock_out, data_oe, rd_n_out;
  logic wr_n_out, ale_out, ctrl_oe, ready_in, hold_grant_out;
  logic bus_reclaim_request;
  logic [15:0] addr_out, data_out, data_in;
  int miscompares = 0, samples_checked = 0, lowcnt, n, k, l0, l1, l2;
  int alecnt, cdcnt, oecnt;
  logic pre_cmd = 0;
  ebc_ctrl ebc_ctrl_i (.ref_clk, .rst_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .bus_reference_clock_out, .addr_out, .data_out, .data_oe, .data_in,
    .rd_n_out, .wr_n_out, .ale_out, .ctrl_oe, .ready_in, .hold_n_in,
    .hold_grant_out, .bus_reclaim_request);
  ebc_mem ebc_mem_i (.ref_clk, .clk_out(bus_reference_clock_out),
    .rd_n(rd_n_out), .wr_n(wr_n_out), .addr(addr_out), .wdata(data_out),
    .dly, .pol, .ready(ready_in), .rdata(data_in));
  initial forever #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    if (!rd_n_out || !wr_n_out)
      lowcnt++;
    if (ale_out)
      alecnt++;
    if (data_oe && rd_n_out && wr_n_out)
      oecnt++;
    // Edges between address setup and the command: delay plus data setup
    if (ale_out)
      pre_cmd = 1'b1;
    else if (!rd_n_out || !wr_n_out)
      pre_cmd = 1'b0;
    else if (pre_cmd)
      cdcnt++;
  end
  task tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 50)
    begin
      @(posedge ref_clk);
      n++;
    end
    // Read data is taken at the edge that ends the wait, then released
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n == 50)
      miscompares++;
  endtask
  task automatic wt(ref logic s, input logic v);
    k = 0;
    while (s !== v && k < 200)
    begin
      @(posedge ref_clk);
      k++;
    end
    if (k == 200)
      miscompares++;
  endtask
  task cmd(input logic w, input logic [15:0] a);
    acc(1, ebc_pkg::ADDR_ADDR, {a, 14'h0, w, 1'b1});
  endtask
  task cyc(input logic w, input logic [15:0] a, output int len);
    lowcnt = 0;
    alecnt = 0;
    cdcnt = 0;
    oecnt = 0;
    cmd(w, a);
    q = 32'h3;
    k = 0;
    while (q[1:0] !== 2'h0 && k < 200)
    begin
      acc(0, ebc_pkg::ADDR_STATUS, 0);
      k++;
    end
    if (k == 200)
      miscompares++;
    len = lowcnt;
  endtask
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    acc(1, ebc_pkg::ADDR_TIMING, 0);
    acc(1, ebc_pkg::ADDR_DATA, 32'ha5c3);
    cyc(1, 16'h0003, l0);
    acc(1, ebc_pkg::ADDR_TIMING, 32'(4) << ebc_pkg::TF_E);
    cyc(1, 16'h0004, l1);
    chk("access_len", 8, l1 - l0);
    cyc(0, 16'h0003, l2);
    acc(0, ebc_pkg::ADDR_DATA, 0);
    chk("read_data", 32'ha5c3, {16'h0, q[15:0]});
    // Setup 2+3 periods on a window change, delay 4, data setup 2, hold 4
    acc(1, ebc_pkg::ADDR_TIMING, 32'(3) << ebc_pkg::TF_F
      | 32'(1) << ebc_pkg::TF_D | 32'(3) << ebc_pkg::TF_C
      | 32'(3) << ebc_pkg::TF_AB_EXT | 32'(1) << ebc_pkg::TF_AB);
    cyc(1, 16'h1007, l0);
    chk("setup_len", 10, alecnt);
    chk("cmd_delay_len", 12, cdcnt);
    chk("data_hold_len", 12, oecnt);
    chk("short_access", 2, l0);
    cyc(1, 16'h1008, l0);
    chk("same_window", 4, alecnt);
    $display("timing test done");
    acc(1, ebc_pkg::ADDR_TIMING, 0);
    acc(1, ebc_pkg::ADDR_CTRL, 3);
    cyc(0, 16'h0003, l0);
    dly <= 4'h5;
    cyc(0, 16'h0003, l1);
    chk("ready_wait", 4, l1 - l0);
    pol <= 1'b0;
    acc(1, ebc_pkg::ADDR_CTRL, 1);
    cyc(0, 16'h0003, l2);
    chk("ready_pol", l1, l2);
    pol <= 1'b1;
    acc(1, ebc_pkg::ADDR_CTRL, 7);
    cyc(0, 16'h0003, l2);
    chk("async_wait", 1, l2 >= l1 + 2);
    $display("ready test done");
    acc(1, ebc_pkg::ADDR_CTRL, 0);
    hold_n_in <= 1'b0;
    wt(hold_grant_out, 1);
    chk("bus_float", 0, ctrl_oe);
    lowcnt = 0;
    cmd(1, 16'h0005);
    wt(bus_reclaim_request, 1);
    chk("reclaim", 1, bus_reclaim_request);
    chk("no_cycle", 0, lowcnt);
    hold_n_in <= 1'b1;
    wt(hold_grant_out, 0);
    wt(wr_n_out, 0);
    wt(wr_n_out, 1);
    chk("regained", 1, lowcnt > 0);
    acc(1, ebc_pkg::ADDR_TIMING, 32'(31) << ebc_pkg::TF_E);
    cmd(1, 16'h0006);
    wt(wr_n_out, 0);
    hold_n_in <= 1'b0;
    wt(hold_grant_out, 1);
    acc(0, ebc_pkg::ADDR_STATUS, 0);
    chk("done_first", 1, q[4]);
    hold_n_in <= 1'b1;
    wt(hold_grant_out, 0);
    $display("hold test done");
    tally_and_finish();
  end
  initial
  begin
    #200000;
    miscompares++;
    tally_and_finish();
  end
endmodule
bind ebc_ctrl ebc_chk ebc_chk_i (.ref_clk, .rst_n, .avs_read, .avs_write,
  .avs_waitrequest, .rd_n_out, .wr_n_out, .ale_out, .ctrl_oe, .data_oe,
  .hold_n_in, .hold_grant_out, .bus_reclaim_request);
`default_nettype wire
